// File: core/wtl_pkg.sv
// Constants, field layouts and carrier types of the wake timer block.
// Assumes a 10 MHz system clock and byte addresses four times the register index.
//
// Function
// [RULE1] Wake timer ticks at 32.768 kHz from the internal RC time base by default.
// [RULE2] Entering sleep with timer enabled counts out the programmed period.
// [RULE3] Expiry with wake interrupt enabled asserts interrupt; host reads status to confirm.
// [RULE4] Sixteen-bit current count readable anytime, high byte then low byte, read-only.
// [RULE5] Period equals four times mantissa times two to exponent, in 32.768 kHz ticks.
// [RULE6] Exponent in bits 4..0 resetting to 03h; mantissa high then low byte.
// [RULE7] Enabled wake interrupt at expiry drives interrupt low and starts main crystal.
// [RULE8] Without wake interrupt, expiry only pulses the routed output; state unchanged.
// [RULE9] External crystal select turns GPIO0 into the 32 kHz crystal pin.
// [RULE10] External crystal select times timer, host clock source and duty mode.
// [RULE11] Duty mode wakes receiver each period, returns to sleep without valid signal.
// [RULE12] Preamble plus sync keeps receiver on for the programmed window.
// [RULE13] One exponent field scales both wake period and receive window.
// [RULE14] Eight-bit receive window value lives in its own register.
// [RULE15] Window equals four times window value times two to shared exponent ticks.
// [RULE16] Wake status stays set until host reads its status register, read clears; the code also clears any status bit written as one.

package wtl_pkg;

    // ----------------
    // Clocking
    // ----------------
    localparam int unsigned SYS_CLK_HZ = 10_000_000;
    localparam int unsigned LF_CLK_HZ = 32_768;
    localparam logic [24:0] SYS_CLK_HZ_W = 25'(SYS_CLK_HZ);
    localparam logic [24:0] LF_CLK_HZ_W = 25'(LF_CLK_HZ);
    localparam logic [33:0] WAKE_SCALE = 34'h4;

    // ----------------
    // Register indices (byte address = index * 4)
    // ----------------
    localparam logic [5:0] IDX_IRQ_STATUS1 = 6'h03;
    localparam logic [5:0] IDX_IRQ_STATUS2 = 6'h04;
    localparam logic [5:0] IDX_IRQ_ENABLE2 = 6'h06;
    localparam logic [5:0] IDX_OP_CTRL1 = 6'h07;
    localparam logic [5:0] IDX_OP_CTRL2 = 6'h08;
    localparam logic [5:0] IDX_WAKE_PERIOD_EXPONENT = 6'h14;
    localparam logic [5:0] IDX_WAKE_PERIOD_MANTISSA_HIGH = 6'h15;
    localparam logic [5:0] IDX_WAKE_PERIOD_MANTISSA_LOW = 6'h16;
    localparam logic [5:0] IDX_WAKE_COUNT_HIGH = 6'h17;
    localparam logic [5:0] IDX_WAKE_COUNT_LOW = 6'h18;
    localparam logic [5:0] IDX_RX_WINDOW_DURATION = 6'h19;

    // ----------------
    // Reset values
    // ----------------
    localparam logic [7:0] RST_IRQ_ENABLE2 = 8'h03;
    localparam logic [7:0] RST_OP_CTRL1 = 8'h01;
    localparam logic [7:0] RST_OP_CTRL2 = 8'h00;
    localparam logic [7:0] RST_EXPONENT = 8'h03;
    localparam logic [7:0] RST_MANT_HIGH = 8'h00;
    localparam logic [7:0] RST_MANT_LOW = 8'h00;
    localparam logic [7:0] RST_RX_WINDOW = 8'h00;

    // ----------------
    // Field positions
    // ----------------
    localparam int unsigned CTRL1_ENWT_BIT = 5;
    localparam int unsigned CTRL1_EXT_XTAL_BIT = 4;
    localparam int unsigned CTRL1_XTON_BIT = 0;
    localparam int unsigned CTRL2_LDC_BIT = 2;
    localparam int unsigned ST2_SYNC_BIT = 7;
    localparam int unsigned ST2_PRE_VALID_BIT = 6;
    localparam int unsigned ST2_PRE_INVALID_BIT = 5;
    localparam int unsigned ST2_WAKE_BIT = 3;
    localparam logic [7:0] EXPONENT_MASK = 8'h1f;

    // ----------------
    // AXI responses
    // ----------------
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ----------------
    // Types
    // ----------------
    typedef enum logic [1:0] {
        WTL_ST_IDLE = 2'b00,
        WTL_ST_LISTEN = 2'b01,
        WTL_ST_WINDOW = 2'b10
    } wtl_state_t;

    typedef struct packed {
        logic preamble_valid;
        logic preamble_invalid;
        logic sync_detect;
    } wtl_rx_evt_t;

    typedef struct packed {
        logic xtal_on;
        logic rx_on;
        logic gpio0_xtal_mode;
        logic lf_src_ext;
        logic wake_pulse;
    } wtl_radio_ctl_t;

endpackage

// File: core/wtl_wake_timer.sv
// Wake timer, 32 kHz time base selection and low duty cycle receive control.
// Assumes AXI4-Lite master on sys_clk and radio inputs synchronous to sys_clk.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps

module wtl_wake_timer (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Radio side
    input wire logic ext_lf_xtal_in,
    input wire wtl_pkg::wtl_rx_evt_t rx_evt,
    output wtl_pkg::wtl_radio_ctl_t radio_ctl,
    // Host interrupt
    output logic irq_out_low_active
);
    import wtl_pkg::*;

    function automatic logic is_reg(input logic [7:0] addr, input logic [5:0] idx);
        is_reg = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
    endfunction

    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = is_reg(addr, IDX_IRQ_STATUS1) || is_reg(addr, IDX_IRQ_STATUS2) ||
                    is_reg(addr, IDX_IRQ_ENABLE2) || is_reg(addr, IDX_OP_CTRL1) ||
                    is_reg(addr, IDX_OP_CTRL2) ||
                    (addr[7:2] >= IDX_WAKE_PERIOD_EXPONENT && addr[7:2] <= IDX_RX_WINDOW_DURATION &&
                     addr[1:0] == 2'b00);
    endfunction

    // ----------------
    // Declarations
    // ----------------
    logic [24:0] acc_q, acc_d;
    logic rc_tick, ext_prev_q, lf_tick;
    logic [7:0] ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d, mask_q, mask_d;
    logic [7:0] exp_q, exp_d, mant_hi_q, mant_hi_d, mant_lo_q, mant_lo_d;
    logic [7:0] win_val_q, win_val_d, status_q, status_d, evt_vec, rd_clr;
    logic [33:0] pre_q, pre_d, pre_lim, wpre_q, wpre_d;
    logic [15:0] wtv_q, wtv_d, wtv_inc;
    logic [7:0] wcnt_q, wcnt_d;
    logic expire, sleeping, running, pre_seen_q, pre_seen_d, win_done;
    logic wake_pulse_q, irq_n_q, irq_n_d;
    wtl_state_t st_q, st_d;
    logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic do_wr, do_rd, wr_en;
    logic [7:0] wbyte, rbyte;

    // ----------------
    // Low-frequency time base
    // ----------------
    // Fractional divider: average 32768 ticks per second from 10 MHz
    always_comb begin
        logic [24:0] sum;
        sum = acc_q + LF_CLK_HZ_W;
        rc_tick = 1'b0;
        acc_d = sum;
        if (sum >= SYS_CLK_HZ_W) begin
            acc_d = sum - SYS_CLK_HZ_W;
            rc_tick = 1'b1;
        end
    end

    // External crystal on GPIO0 replaces the RC base for every consumer
    assign lf_tick = ctrl1_q[CTRL1_EXT_XTAL_BIT] ? (ext_lf_xtal_in & ~ext_prev_q) : rc_tick; // [RULE1] [RULE10]

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_q <= 25'h0;
            ext_prev_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            ext_prev_q <= ext_lf_xtal_in;
        end
    end

    // ----------------
    // Wake timer counter
    // ----------------
    assign sleeping = ~ctrl1_q[CTRL1_XTON_BIT];
    assign running = ctrl1_q[CTRL1_ENWT_BIT] & sleeping; // [RULE2]
    // Shared exponent scales prescaler for period and window
    assign pre_lim = (WAKE_SCALE << (exp_q & EXPONENT_MASK)) - 34'h1; // [RULE5] [RULE13]
    assign wtv_inc = wtv_q + 16'h1;

    always_comb begin
        pre_d = pre_q;
        wtv_d = wtv_q;
        expire = 1'b0;
        if (!running) begin
            pre_d = 34'h0;
            wtv_d = 16'h0;
        end else if (lf_tick) begin
            if (pre_q >= pre_lim) begin
                pre_d = 34'h0;
                // Mantissa zero wraps as a full 65536 count
                if (wtv_inc == {mant_hi_q, mant_lo_q}) begin // [RULE5] [RULE6]
                    wtv_d = 16'h0;
                    expire = 1'b1;
                end else begin
                    wtv_d = wtv_inc;
                end
            end else begin
                pre_d = pre_q + 34'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_q <= 34'h0;
            wtv_q <= 16'h0;
            wake_pulse_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            wtv_q <= wtv_d;
            wake_pulse_q <= expire; // [RULE8]
        end
    end

    // ----------------
    // Low duty cycle receive sequencer
    // ----------------
    assign win_done = (win_val_q == 8'h0) ||
                      (lf_tick && wpre_q >= pre_lim && (wcnt_q + 8'h1) == win_val_q); // [RULE15]

    always_comb begin
        st_d = st_q;
        wpre_d = wpre_q;
        wcnt_d = wcnt_q;
        pre_seen_d = pre_seen_q;
        case (st_q)
            WTL_ST_IDLE: begin
                pre_seen_d = 1'b0;
                if (expire && ctrl2_q[CTRL2_LDC_BIT]) begin
                    st_d = WTL_ST_LISTEN; // [RULE11]
                end
            end
            WTL_ST_LISTEN: begin
                if (rx_evt.preamble_valid) begin
                    pre_seen_d = 1'b1;
                end
                if (rx_evt.preamble_invalid || !sleeping || !ctrl2_q[CTRL2_LDC_BIT]) begin
                    st_d = WTL_ST_IDLE; // [RULE11]
                end else if (rx_evt.sync_detect && (pre_seen_q || rx_evt.preamble_valid)) begin
                    st_d = WTL_ST_WINDOW; // [RULE12]
                    wpre_d = 34'h0;
                    wcnt_d = 8'h0;
                end
            end
            WTL_ST_WINDOW: begin
                if (win_done || !sleeping) begin
                    st_d = WTL_ST_IDLE; // [RULE12]
                end else if (lf_tick) begin
                    if (wpre_q >= pre_lim) begin
                        wpre_d = 34'h0;
                        wcnt_d = wcnt_q + 8'h1;
                    end else begin
                        wpre_d = wpre_q + 34'h1;
                    end
                end
            end
            default: begin
                st_d = WTL_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= WTL_ST_IDLE;
            wpre_q <= 34'h0;
            wcnt_q <= 8'h0;
            pre_seen_q <= 1'b0;
        end else begin
            st_q <= st_d;
            wpre_q <= wpre_d;
            wcnt_q <= wcnt_d;
            pre_seen_q <= pre_seen_d;
        end
    end

    // ----------------
    // AXI4-Lite slave
    // ----------------
    assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
    assign s_axi_wready = ~w_hold_q & ~bvalid_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    assign do_wr = aw_hold_q & w_hold_q & ~bvalid_q;
    assign do_rd = s_axi_arvalid & ~rvalid_q;
    assign wr_en = do_wr & wstrb_q[0] & is_mapped(awaddr_q);
    assign wbyte = wdata_q[7:0];

    // Read mux; count registers are live values
    always_comb begin
        rbyte = 8'h0;
        case (s_axi_araddr[7:2])
            IDX_IRQ_STATUS2: rbyte = status_q; // [RULE3]
            IDX_IRQ_ENABLE2: rbyte = mask_q;
            IDX_OP_CTRL1: rbyte = ctrl1_q;
            IDX_OP_CTRL2: rbyte = ctrl2_q;
            IDX_WAKE_PERIOD_EXPONENT: rbyte = exp_q & EXPONENT_MASK; // [RULE6]
            IDX_WAKE_PERIOD_MANTISSA_HIGH: rbyte = mant_hi_q;
            IDX_WAKE_PERIOD_MANTISSA_LOW: rbyte = mant_lo_q;
            IDX_WAKE_COUNT_HIGH: rbyte = wtv_q[15:8]; // [RULE4]
            IDX_WAKE_COUNT_LOW: rbyte = wtv_q[7:0]; // [RULE4]
            IDX_RX_WINDOW_DURATION: rbyte = win_val_q; // [RULE14]
            default: rbyte = 8'h0;
        endcase
    end

    always_comb begin
        aw_hold_d = aw_hold_q;
        w_hold_d = w_hold_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (do_wr) begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (do_rd) begin
            rvalid_d = 1'b1;
            rdata_d = {24'h0, rbyte};
            rresp_d = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
        end else begin
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // ----------------
    // Control, status and mask registers
    // ----------------
    always_comb begin
        evt_vec = 8'h0;
        evt_vec[ST2_WAKE_BIT] = expire;
        evt_vec[ST2_SYNC_BIT] = rx_evt.sync_detect & (st_q != WTL_ST_IDLE);
        evt_vec[ST2_PRE_VALID_BIT] = rx_evt.preamble_valid & (st_q != WTL_ST_IDLE);
        evt_vec[ST2_PRE_INVALID_BIT] = rx_evt.preamble_invalid & (st_q != WTL_ST_IDLE);
        rd_clr = 8'h0;
        if (do_rd && is_reg(s_axi_araddr, IDX_IRQ_STATUS2)) begin
            rd_clr = 8'hff; // [RULE16]
        end
        if (wr_en && is_reg(awaddr_q, IDX_IRQ_STATUS2)) begin
            rd_clr = rd_clr | wbyte;
        end
        // New event wins over a clear in the same cycle
        status_d = (status_q & ~rd_clr) | evt_vec; // [RULE16]
    end

    always_comb begin
        ctrl1_d = ctrl1_q;
        ctrl2_d = ctrl2_q;
        mask_d = mask_q;
        exp_d = exp_q;
        mant_hi_d = mant_hi_q;
        mant_lo_d = mant_lo_q;
        win_val_d = win_val_q;
        if (wr_en) begin
            case (awaddr_q[7:2])
                IDX_IRQ_ENABLE2: mask_d = wbyte;
                IDX_OP_CTRL1: ctrl1_d = wbyte;
                IDX_OP_CTRL2: ctrl2_d = wbyte;
                IDX_WAKE_PERIOD_EXPONENT: exp_d = wbyte & EXPONENT_MASK; // [RULE6]
                IDX_WAKE_PERIOD_MANTISSA_HIGH: mant_hi_d = wbyte; // [RULE6]
                IDX_WAKE_PERIOD_MANTISSA_LOW: mant_lo_d = wbyte; // [RULE6]
                IDX_RX_WINDOW_DURATION: win_val_d = wbyte; // [RULE14]
                default: begin
                end
            endcase
        end
        // Enabled wake interrupt brings up the main crystal; hardware set wins
        if (expire && mask_q[ST2_WAKE_BIT]) begin
            ctrl1_d[CTRL1_XTON_BIT] = 1'b1; // [RULE7] [RULE8]
        end
        irq_n_d = ~|(status_d & mask_d); // [RULE3] [RULE7]
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl1_q <= RST_OP_CTRL1;
            ctrl2_q <= RST_OP_CTRL2;
            mask_q <= RST_IRQ_ENABLE2;
            exp_q <= RST_EXPONENT;
            mant_hi_q <= RST_MANT_HIGH;
            mant_lo_q <= RST_MANT_LOW;
            win_val_q <= RST_RX_WINDOW;
            status_q <= 8'h0;
            irq_n_q <= 1'b1;
        end else begin
            ctrl1_q <= ctrl1_d;
            ctrl2_q <= ctrl2_d;
            mask_q <= mask_d;
            exp_q <= exp_d;
            mant_hi_q <= mant_hi_d;
            mant_lo_q <= mant_lo_d;
            win_val_q <= win_val_d;
            status_q <= status_d;
            irq_n_q <= irq_n_d;
        end
    end

    // ----------------
    // Outputs
    // ----------------
    assign irq_out_low_active = irq_n_q;
    assign radio_ctl.xtal_on = ctrl1_q[CTRL1_XTON_BIT];
    assign radio_ctl.rx_on = (st_q != WTL_ST_IDLE); // [RULE11] [RULE12]
    assign radio_ctl.gpio0_xtal_mode = ctrl1_q[CTRL1_EXT_XTAL_BIT]; // [RULE9]
    assign radio_ctl.lf_src_ext = ctrl1_q[CTRL1_EXT_XTAL_BIT]; // [RULE10]
    assign radio_ctl.wake_pulse = wake_pulse_q;

endmodule

// File: tb/wtl_radio_model.sv
// Far-side model: external 32 kHz crystal and demodulator event pulses.
// Assumes bench commands change just after rising sys_clk edges.
`timescale 1ns/10ps

module wtl_radio_model (
    // Clock
    input wire logic sys_clk,
    // Bench commands
    input wire logic xtal_run,
    input wire logic [2:0] evt_cmd,
    // Radio side
    output logic ext_lf_xtal_in,
    output wtl_pkg::wtl_rx_evt_t rx_evt
);
    import wtl_pkg::*;
    logic [1:0] div_q = 2'h0;
    // Crystal of eight clock periods, held low while stopped
    always @(posedge sys_clk) begin
        div_q <= xtal_run ? 2'(div_q + 2'h1) : 2'h0;
        ext_lf_xtal_in <= xtal_run && (ext_lf_xtal_in ^ (div_q == 2'h3));
    end
    always @(posedge sys_clk) begin
        rx_evt <= wtl_rx_evt_t'(evt_cmd);
    end
endmodule

// File: tb/wtl_wake_timer_asserts.sv
// Port checker of the wake timer, bound into every instance.
// Assumes the single sys_clk domain and its active-high reset.
`timescale 1ns/10ps

module wtl_wake_timer_asserts (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Radio and host
    input wire wtl_pkg::wtl_radio_ctl_t radio_ctl,
    input wire logic irq_out_low_active
);
    import wtl_pkg::*;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_ctrl1_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0]
            && s_axi_awaddr == {IDX_OP_CTRL1, 2'b00};
    endsequence
    sequence s_status_rd;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == {IDX_IRQ_STATUS2, 2'b00} && !radio_ctl.rx_on;
    endsequence
    a_ctrl1_pins: assert property (s_ctrl1_wr |-> ##2 radio_ctl.gpio0_xtal_mode == $past(s_axi_wdata[4], 2))
        else $error("pin mode not loaded");
    a_src_pair: assert property (radio_ctl.gpio0_xtal_mode == radio_ctl.lf_src_ext)
        else $error("source and pin disagree");
    a_pulse_single: assert property (radio_ctl.wake_pulse |=> !radio_ctl.wake_pulse)
        else $error("long wake pulse");
    a_wake_asleep: assert property (radio_ctl.wake_pulse |-> !$past(radio_ctl.xtal_on, 2))
        else $error("expiry while awake");
    a_rx_from_wake: assert property ($rose(radio_ctl.rx_on) |-> ##[0:1] radio_ctl.wake_pulse)
        else $error("rx without expiry");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_status_clear: assert property (s_status_rd ##1 !radio_ctl.wake_pulse |-> ##[0:1] irq_out_low_active)
        else $error("irq low after status read");
endmodule

bind wtl_wake_timer wtl_wake_timer_asserts u_wtl_wake_timer_asserts (.sys_clk, .sys_rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .radio_ctl, .irq_out_low_active);

// File: tb/wtl_wake_timer_tb.sv
// Self-checking bench: register bus master, radio model, timing checks.
// Assumes the radio model and the bound checker compile before it.
`timescale 1ns/10ps

module wtl_wake_timer_tb;
    import wtl_pkg::*;
    localparam int TICK_CYC = 8;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_out_low_active, ext_lf_xtal_in;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic xtal_run = 1'b0;
    logic [2:0] evt_cmd = 3'h0;
    logic [15:0] lfsr = 16'hb467;
    wtl_rx_evt_t rx_evt;
    wtl_radio_ctl_t radio_ctl;
    int bad_count = 0;
    int n_checks = 0;
    logic [5:0] ri [7] = '{IDX_IRQ_ENABLE2, IDX_OP_CTRL1, IDX_OP_CTRL2, IDX_WAKE_PERIOD_EXPONENT,
        IDX_WAKE_PERIOD_MANTISSA_HIGH, IDX_WAKE_PERIOD_MANTISSA_LOW, IDX_RX_WINDOW_DURATION};
    logic [7:0] rv [7] = '{8'h03, 8'h01, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
    wtl_wake_timer u_wtl_wake_timer (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_lf_xtal_in,
        .rx_evt, .radio_ctl, .irq_out_low_active);
    wtl_radio_model u_wtl_radio_model (.sys_clk, .xtal_run, .evt_cmd, .ext_lf_xtal_in, .rx_evt);
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic int unsigned exp_ticks(input int unsigned r, input int unsigned m);
        return 4 * m * (1 << r);
    endfunction
    function automatic logic sel(input int k);
        return k == 0 ? irq_out_low_active : (k == 1 ? radio_ctl.rx_on : radio_ctl.wake_pulse);
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic give_up();
        bad_count++;
        print_verdict();
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        @(posedge sys_clk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                return;
            end
        end
        give_up();
    endtask
    task automatic rd(input logic [5:0] idx, output logic [7:0] d, output logic [1:0] resp);
        @(posedge sys_clk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                d = s_axi_rdata[7:0];
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                return;
            end
            // Ready one cycle after valid, so read data must hold
            s_axi_rready <= s_axi_rvalid;
        end
        give_up();
    endtask
    task automatic chk(input logic [5:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        logic [1:0] r;
        rd(idx, d, r);
        cmp8(d, exp);
    endtask
    task automatic wait_lvl(input int k, input logic lvl, input int lim, output int n);
        for (n = 0; n < lim; n++) begin
            @(posedge sys_clk);
            if (sel(k) === lvl) return;
        end
        give_up();
    endtask
    initial begin
        logic [7:0] v;
        logic [1:0] r;
        int n;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        cmp8(8'(irq_out_low_active), 8'h01);
        cmp8(8'(radio_ctl), 8'h10);
        for (int i = 0; i < 7; i++) chk(ri[i], rv[i]);
        rd(6'h0f, v, r);
        cmp8({6'h0, r}, 8'h02);
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            wr(IDX_WAKE_PERIOD_MANTISSA_HIGH, lfsr[15:8]);
            wr(IDX_RX_WINDOW_DURATION, lfsr[7:0]);
            chk(IDX_WAKE_PERIOD_MANTISSA_HIGH, lfsr[15:8]);
            chk(IDX_RX_WINDOW_DURATION, lfsr[7:0]);
        end
        // Free-running period with the wake interrupt masked
        wr(IDX_WAKE_PERIOD_EXPONENT, 8'h01);
        wr(IDX_WAKE_PERIOD_MANTISSA_HIGH, 8'h00);
        wr(IDX_WAKE_PERIOD_MANTISSA_LOW, 8'h03);
        wr(IDX_IRQ_ENABLE2, 8'h00);
        xtal_run <= 1'b1;
        wr(IDX_OP_CTRL1, 8'h30);
        wait_lvl(2, 1'b1, 3000, n);
        wait_lvl(2, 1'b0, 4, n);
        wait_lvl(2, 1'b1, 3000, n);
        cmp8(8'(n + 2), 8'(exp_ticks(1, 3) * TICK_CYC));
        cmp8({radio_ctl.xtal_on, irq_out_low_active}, 8'h01);
        repeat (90) @(posedge sys_clk);
        chk(IDX_WAKE_COUNT_LOW, 8'h01);
        chk(IDX_WAKE_COUNT_HIGH, 8'h00);
        chk(IDX_IRQ_STATUS2, 8'h08);
        chk(IDX_IRQ_STATUS2, 8'h00);
        // Wake interrupt enabled: crystal starts, timer stops
        wr(IDX_IRQ_ENABLE2, 8'h08);
        wait_lvl(0, 1'b0, 3000, n);
        cmp8(8'(radio_ctl.xtal_on), 8'h01);
        chk(IDX_OP_CTRL1, 8'h31);
        chk(IDX_IRQ_STATUS2, 8'h08);
        wait_lvl(0, 1'b1, 4, n);
        wr(IDX_WAKE_COUNT_LOW, 8'hff);
        chk(IDX_WAKE_COUNT_LOW, 8'h00);
        // Duty mode: no valid signal, then preamble with sync
        wr(IDX_WAKE_PERIOD_EXPONENT, 8'h00);
        wr(IDX_WAKE_PERIOD_MANTISSA_LOW, 8'h02);
        wr(IDX_RX_WINDOW_DURATION, 8'h01);
        wr(IDX_IRQ_ENABLE2, 8'h00);
        wr(IDX_OP_CTRL2, 8'h04);
        wr(IDX_OP_CTRL1, 8'h30);
        wait_lvl(1, 1'b1, 3000, n);
        evt_cmd <= 3'b010;
        @(posedge sys_clk);
        evt_cmd <= 3'h0;
        wait_lvl(1, 1'b0, 6, n);
        wait_lvl(1, 1'b1, 3000, n);
        evt_cmd <= 3'b101;
        @(posedge sys_clk);
        evt_cmd <= 3'h0;
        wait_lvl(1, 1'b0, 100, n);
        cmp8(8'(n + 2), 8'(exp_ticks(0, 1) * TICK_CYC));
        print_verdict();
    end
endmodule
